//--- verilog/host_power_cfg.svh
// Constants for the host power switch and host watchdog block.
`ifndef HOST_POWER_CFG_SVH
`define HOST_POWER_CFG_SVH

`define HPW_CLK_NS          4
`define HPW_TICK_NS         31250000
`define HPW_TICKS_PER_SEC   5'h1f
`define HPW_ON_HOLD_TICKS   8'h08
`define HPW_OFF_HOLD_TICKS  8'h80
`define HPW_RST_HOLD_TICKS  8'h80
`define HPW_RST_PULSE_TICKS 8'h20
`define HPW_EXT_MAX_TICKS   8'ha0
`define HPW_LEN_HOLD        8'hff

`define HPW_MB_AUTO   0
`define HPW_MB_RINV   1
`define HPW_MB_PINV   2
`define HPW_MB_BLANK  4
`define HPW_MB_RESET  5
`define HPW_MB_ON     6
`define HPW_MB_OFF    7

`define HPW_CMD_ATX   8'h1c
`define HPW_CMD_WDOG  8'h1d
`define HPW_CMD_STAT  8'h1e
`define HPW_REPLY_BIT 8'h40

`define HPW_MASK_RST  8'h00
`define HPW_PULSE_RST 8'h20
`define HPW_SENSE_RST 1'b1

`define HPW_A_DATA0   8'h00
`define HPW_A_DATA1   8'h01
`define HPW_A_DATA2   8'h02
`define HPW_A_LEN     8'h03
`define HPW_A_TYPE    8'h04
`define HPW_A_REPLY   8'h05
`define HPW_A_LIVE    8'h06
`define HPW_A_STAT    8'h10
`define HPW_STAT_LEN  8'h0f
`define HPW_SB_MASK   8'h07
`define HPW_SB_WDOG   8'h08
`define HPW_SB_SENSE  8'h0b

`endif

//--- verilog/host_power_pkg.sv
// Types shared by the host power switch and watchdog block.
package host_power_pkg;

	typedef enum logic [2:0] {
		S_IDLE     = 3'b000,
		S_PWR      = 3'b001,
		S_PWR_EXT  = 3'b010,
		S_PWR_HOLD = 3'b011,
		S_RST      = 3'b100
	} state_t;

	typedef enum logic [1:0] {
		MSG_NONE  = 2'b00,
		MSG_ON    = 2'b01,
		MSG_OFF   = 2'b10,
		MSG_RESET = 2'b11
	} msg_t;

	typedef struct packed {
		logic [7:0] len;
		logic [7:0] d0;
		logic [7:0] d1;
		logic [7:0] d2;
	} cmd_t;

	typedef struct packed {
		logic [7:0] mask;
		logic [7:0] pulse_len;
		logic       sense_sel;
	} cfg_t;

endpackage : host_power_pkg

//--- verilog/host_power_switch_watchdog.sv
// Host power and reset switch control with host watchdog.
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "host_power_cfg.svh"

module host_power_switch_watchdog #(
	parameter int unsigned TICK_CYCLES = `HPW_TICK_NS / `HPW_CLK_NS
) (
	input  wire logic                  mclk_i,             // System clock
	input  wire logic                  sys_rst_i,          // Synchronous reset
	input  wire logic [7:0]            addr_i,             // Register address
	input  wire logic [7:0]            wr_data_i,          // Register write data
	input  wire logic                  wr_en_i,            // Write strobe
	input  wire logic                  rd_en_i,            // Read strobe
	output logic [7:0]                 rd_data_o,          // Read data, next cycle
	input  wire logic                  standby_supply_i,   // Internal supply sense
	input  wire logic                  sense_gpio_i,       // GPIO pin sense
	input  wire logic                  key_confirm_i,      // Confirm key, high pressed
	input  wire logic                  key_cancel_i,       // Cancel key, high pressed
	input  wire logic                  reset_line_i,       // Host reset line level
	output logic                       reset_line_o,       // Host reset drive level
	output logic                       reset_line_oe_n_o,  // Low while driving reset
	input  wire logic                  power_line_i,       // Host power line level
	output logic                       power_line_o,       // Host power drive level
	output logic                       power_line_oe_n_o,  // Low while driving power
	output logic                       display_blank_o,    // Blank the display
	output logic                       backlight_off_o,    // Backlight off
	output logic                       self_restart_o,     // Restart pulse for module
	output host_power_pkg::msg_t       msg_o               // Message to show
);
	import host_power_pkg::*;

	logic [5:0]  async_in;
	logic [5:0]  sync_a;
	logic [5:0]  sync_b;
	logic        sense;
	logic        sense_q;
	logic        sense_rise;
	logic        key_ok;
	logic        key_no;
	logic [31:0] tick_cnt;
	logic        tick;
	logic [4:0]  sub_cnt;
	logic        sec_tick;
	logic [7:0]  confirm_ticks;
	logic [7:0]  cancel_ticks;
	cmd_t        cmd;
	cfg_t        cfg;
	logic [7:0]  last_type;
	logic [7:0]  reply;
	logic        cmd_go;
	logic        cmd_ok;
	logic        wd_en;
	logic [7:0]  wd_count;
	logic        wd_fire;
	logic        wd_pend;
	state_t      state;
	logic [7:0]  pulse_ticks;
	logic [7:0]  next_ticks;
	logic        restart_after;
	logic        sense_at;
	logic        idle_rst;
	logic        idle_pwr;
	logic        drive_rst;
	logic        drive_pwr;
	logic [7:0]  stat_idx;
	logic [7:0]  rd_mux;

	assign async_in = {power_line_i, reset_line_i, key_cancel_i,
		key_confirm_i, sense_gpio_i, standby_supply_i};

	// Two-flop synchronisers for every pin input.
	for (genvar i = 0; i < 6; i++) begin : g_sync
		always_ff @(posedge mclk_i) begin
			if (sys_rst_i) begin
				sync_a[i] <= 1'b0;
				sync_b[i] <= 1'b0;
			end else begin
				sync_a[i] <= async_in[i];
				sync_b[i] <= sync_a[i];
			end
		end
	end

	assign sense      = cfg.sense_sel ? sync_b[0] : sync_b[1];
	assign key_ok     = sync_b[2];
	assign key_no     = sync_b[3];
	assign sense_rise = sense & ~sense_q;

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			sense_q <= 1'b0;
		end else begin
			sense_q <= sense;
		end
	end

	// Timebase: 1/32 s tick and one-second tick.
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			tick_cnt <= 32'h0000_0000;
			tick     <= 1'b0;
			sub_cnt  <= 5'h00;
			sec_tick <= 1'b0;
		end else begin
			if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
				tick_cnt <= 32'h0000_0000;
				tick     <= 1'b1;
			end else begin
				tick_cnt <= tick_cnt + 32'h0000_0001;
				tick     <= 1'b0;
			end
			if (tick) begin
				sub_cnt <= sub_cnt + 5'h01;
			end
			sec_tick <= tick && (sub_cnt == `HPW_TICKS_PER_SEC);
		end
	end

	// Key hold timers, counted only while idle so a held key must reach the hold time again for each action.
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i || state != S_IDLE || !key_ok) begin
			confirm_ticks <= 8'h00;
		end else if (tick && confirm_ticks != 8'hff) begin
			confirm_ticks <= confirm_ticks + 8'h01;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i || state != S_IDLE || !key_no) begin
			cancel_ticks <= 8'h00;
		end else if (tick && cancel_ticks != 8'hff) begin
			cancel_ticks <= cancel_ticks + 8'h01;
		end
	end

	// Command staging: a write of the type register runs the command.
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			cmd       <= '0;
			last_type <= 8'h00;
			cmd_go    <= 1'b0;
		end else begin
			cmd_go <= wr_en_i && addr_i == `HPW_A_TYPE;
			if (wr_en_i) begin
				case (addr_i)
					`HPW_A_DATA0: cmd.d0 <= wr_data_i;
					`HPW_A_DATA1: cmd.d1 <= wr_data_i;
					`HPW_A_DATA2: cmd.d2 <= wr_data_i;
					`HPW_A_LEN:   cmd.len <= wr_data_i;
					`HPW_A_TYPE:  last_type <= wr_data_i;
					default: ;
				endcase
			end
		end
	end

	always_comb begin
		case (last_type)
			`HPW_CMD_ATX:  cmd_ok = cmd.len >= 8'h01 && cmd.len <= 8'h03;
			`HPW_CMD_WDOG: cmd_ok = cmd.len == 8'h01;
			`HPW_CMD_STAT: cmd_ok = cmd.len == 8'h00;
			default:       cmd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			reply <= 8'h00;
		end else if (cmd_go) begin
			reply <= cmd_ok ? (last_type | `HPW_REPLY_BIT) : 8'h00;
		end
	end

	// Switch configuration.
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			cfg.mask      <= `HPW_MASK_RST;
			cfg.pulse_len <= `HPW_PULSE_RST;
			cfg.sense_sel <= `HPW_SENSE_RST;
		end else if (cmd_go && cmd_ok && last_type == `HPW_CMD_ATX) begin
			cfg.mask <= cmd.d0;
			if (cmd.len >= 8'h02 && cmd.d1 != 8'h00) begin
				cfg.pulse_len <= cmd.d1;
			end
			if (cmd.len == 8'h03) begin
				cfg.sense_sel <= cmd.d2[0];
			end
		end
	end

	// Watchdog countdown in seconds.
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i || self_restart_o) begin
			wd_en    <= 1'b0;
			wd_count <= 8'h00;
			wd_fire  <= 1'b0;
		end else begin
			wd_fire <= 1'b0;
			if (cmd_go && cmd_ok && last_type == `HPW_CMD_WDOG) begin
				wd_count <= cmd.d0;
				wd_en    <= cmd.d0 != 8'h00;
			end else if (wd_en && sec_tick) begin
				if (wd_count == 8'h01) begin
					wd_count <= 8'h00;
					wd_en    <= 1'b0;
					wd_fire  <= 1'b1;
				end else begin
					wd_count <= wd_count - 8'h01;
				end
			end
		end
	end

	assign next_ticks = pulse_ticks + 8'h01;

	// Pulse sequencer.
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			state          <= S_IDLE;
			pulse_ticks    <= 8'h00;
			restart_after  <= 1'b0;
			sense_at       <= 1'b0;
			wd_pend        <= 1'b0;
			msg_o          <= MSG_NONE;
			self_restart_o <= 1'b0;
		end else begin
			self_restart_o <= 1'b0;
			case (state)
				S_IDLE: begin
					pulse_ticks <= 8'h00;
					sense_at    <= sense;
					if (wd_pend) begin
						wd_pend       <= 1'b0;
						restart_after <= 1'b0;
						state         <= S_RST;
					end else if (!sense && cfg.mask[`HPW_MB_ON]
							&& confirm_ticks >= `HPW_ON_HOLD_TICKS) begin
						msg_o         <= MSG_ON;
						restart_after <= 1'b1;
						state <= (cfg.pulse_len == `HPW_LEN_HOLD) ? S_PWR_HOLD : S_PWR;
					end else if (sense && cfg.mask[`HPW_MB_RESET]
							&& confirm_ticks >= `HPW_RST_HOLD_TICKS) begin
						msg_o         <= MSG_RESET;
						restart_after <= 1'b1;
						state         <= S_RST;
					end else if (sense && cfg.mask[`HPW_MB_OFF]
							&& cancel_ticks >= `HPW_OFF_HOLD_TICKS) begin
						msg_o         <= MSG_OFF;
						restart_after <= 1'b0;
						state <= (cfg.pulse_len == `HPW_LEN_HOLD) ? S_PWR_HOLD : S_PWR;
					end else if (sense_rise) begin
						self_restart_o <= 1'b1;
					end
				end
				S_PWR: begin
					if (tick) begin
						pulse_ticks <= next_ticks;
						if (next_ticks >= cfg.pulse_len) begin
							pulse_ticks <= 8'h00;
							if (msg_o == MSG_OFF && key_no) begin
								state <= S_PWR_EXT;
							end else begin
								state          <= S_IDLE;
								msg_o          <= MSG_NONE;
								self_restart_o <= restart_after;
							end
						end
					end
				end
				S_PWR_EXT: begin
					if (tick) begin
						pulse_ticks <= next_ticks;
					end
					if (!key_no || (tick && next_ticks >= `HPW_EXT_MAX_TICKS)) begin
						state <= S_IDLE;
						msg_o <= MSG_NONE;
					end
				end
				S_PWR_HOLD: begin
					if (sense != sense_at) begin
						state          <= S_IDLE;
						msg_o          <= MSG_NONE;
						self_restart_o <= restart_after;
					end
				end
				S_RST: begin
					if (tick) begin
						pulse_ticks <= next_ticks;
						if (next_ticks >= `HPW_RST_PULSE_TICKS) begin
							state          <= S_IDLE;
							msg_o          <= MSG_NONE;
							self_restart_o <= restart_after;
						end
					end
				end
				default: begin
					state <= S_IDLE;
					msg_o <= MSG_NONE;
				end
			endcase
			if (wd_fire) begin
				wd_pend <= 1'b1;
			end
		end
	end

	assign drive_rst = state == S_RST;
	assign drive_pwr = state == S_PWR || state == S_PWR_EXT || state == S_PWR_HOLD;

	// Idle levels are learnt only on ticks while the line floats, far from
	// the synchroniser lag that follows a pulse.
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			idle_rst <= 1'b1;
			idle_pwr <= 1'b1;
		end else if (tick) begin
			if (reset_line_oe_n_o && !drive_rst) begin
				idle_rst <= sync_b[4];
			end
			if (power_line_oe_n_o && !drive_pwr) begin
				idle_pwr <= sync_b[5];
			end
		end
	end

	// Line drivers: float when idle, active level only during a pulse.
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			reset_line_o      <= 1'b0;
			reset_line_oe_n_o <= 1'b1;
			power_line_o      <= 1'b0;
			power_line_oe_n_o <= 1'b1;
		end else begin
			reset_line_o <= cfg.mask[`HPW_MB_AUTO] ? ~idle_rst
				: cfg.mask[`HPW_MB_RINV];
			power_line_o <= cfg.mask[`HPW_MB_AUTO] ? ~idle_pwr
				: cfg.mask[`HPW_MB_PINV];
			reset_line_oe_n_o <= ~drive_rst;
			power_line_oe_n_o <= ~drive_pwr;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			display_blank_o <= 1'b0;
			backlight_off_o <= 1'b0;
		end else begin
			display_blank_o <= cfg.mask[`HPW_MB_BLANK] && !sense;
			backlight_off_o <= cfg.mask[`HPW_MB_BLANK] && !sense;
		end
	end

	// Register read path, status block included.
	assign stat_idx = addr_i - `HPW_A_STAT;

	always_comb begin
		rd_mux = 8'h00;
		case (addr_i)
			`HPW_A_DATA0: rd_mux = cmd.d0;
			`HPW_A_DATA1: rd_mux = cmd.d1;
			`HPW_A_DATA2: rd_mux = cmd.d2;
			`HPW_A_LEN:   rd_mux = cmd.len;
			`HPW_A_TYPE:  rd_mux = last_type;
			`HPW_A_REPLY: rd_mux = reply;
			`HPW_A_LIVE:  rd_mux = {2'b00, wd_pend, wd_en, sense, state};
			default: begin
				if (addr_i >= `HPW_A_STAT && stat_idx < `HPW_STAT_LEN) begin
					case (stat_idx)
						`HPW_SB_MASK:  rd_mux = cfg.mask;
						`HPW_SB_WDOG:  rd_mux = wd_count;
						`HPW_SB_SENSE: rd_mux = {7'h00, cfg.sense_sel};
						default:       rd_mux = 8'h00;
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			rd_data_o <= 8'h00;
		end else begin
			rd_data_o <= rd_en_i ? rd_mux : 8'h00;
		end
	end

endmodule : host_power_switch_watchdog
`default_nettype wire

//--- verif/host_atx_model.sv
// Host motherboard model: pulled-up control lines and a power latch.
`timescale 1ns/1ns
`default_nettype none
module host_atx_model (
	input  wire logic clk_i,      // System clock
	input  wire logic rst_i,      // Synchronous reset
	input  wire logic pwr_oe_n_i, // Low while power is driven
	input  wire logic pwr_drv_i,  // Power drive level
	input  wire logic rst_oe_n_i, // Low while reset is driven
	input  wire logic rst_drv_i,  // Reset drive level
	output logic      pwr_line_o, // Power line level
	output logic      rst_line_o, // Reset line level
	output logic      host_on_o   // Host supply sense
);
	logic pwr_oe_q;
	// Released lines rest at the pull-up level.
	assign pwr_line_o = pwr_oe_n_i ? 1'b1 : pwr_drv_i;
	assign rst_line_o = rst_oe_n_i ? 1'b1 : rst_drv_i;
	// The host flips its power state when a power button press ends.
	always_ff @(posedge clk_i) begin
		pwr_oe_q <= rst_i ? 1'b1 : pwr_oe_n_i;
		if (rst_i) begin
			host_on_o <= 1'b0;
		end else if (pwr_oe_n_i && !pwr_oe_q) begin
			host_on_o <= !host_on_o;
		end
	end
endmodule : host_atx_model
`default_nettype wire

//--- verif/host_power_switch_watchdog_assertions.sv
// Port checks for the host power switch and watchdog block.
`timescale 1ns/1ns
`default_nettype none
module host_power_switch_watchdog_chk #(
	parameter int unsigned TICK_CYCLES = 4
) (
	input wire logic       mclk_i,            // System clock
	input wire logic       sys_rst_i,         // Synchronous reset
	input wire logic [7:0] addr_i,            // Register address
	input wire logic       rd_en_i,           // Read strobe
	input wire logic [7:0] rd_data_o,         // Read data
	input wire logic       reset_line_oe_n_o, // Reset drive enable
	input wire logic       power_line_o,      // Power drive level
	input wire logic       power_line_oe_n_o, // Power drive enable
	input wire logic       display_blank_o,   // Display blank
	input wire logic       backlight_off_o,   // Backlight off
	input wire logic       self_restart_o     // Restart pulse
);
	localparam int RST_MAX = 34 * TICK_CYCLES + 4;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	chk_rd_quiet: assert property (!rd_en_i |=> rd_data_o == 8'h00)
		else $error("read data seen without a read strobe");
	chk_stat_tail: assert property (rd_en_i && addr_i >= 8'h1f |=> rd_data_o == 8'h00)
		else $error("data returned past the status block");
	chk_one_pulse: assert property (!(!power_line_oe_n_o && !reset_line_oe_n_o))
		else $error("power and reset driven together");
	chk_restart_short: assert property (self_restart_o |=> !self_restart_o)
		else $error("restart pulse longer than one cycle");
	chk_blank_pair: assert property (display_blank_o == backlight_off_o)
		else $error("blank and backlight disagree");
	chk_rst_min: assert property ($fell(reset_line_oe_n_o) |=> !reset_line_oe_n_o [*8])
		else $error("reset pulse too short");
	chk_rst_max: assert property ($fell(reset_line_oe_n_o) |-> ##[1:RST_MAX] reset_line_oe_n_o)
		else $error("reset pulse too long");
	chk_pwr_steady: assert property (!power_line_oe_n_o && $past(!power_line_oe_n_o) |-> $stable(power_line_o))
		else $error("power level moved inside a pulse");
endmodule : host_power_switch_watchdog_chk
bind host_power_switch_watchdog host_power_switch_watchdog_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
	.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .rd_en_i(rd_en_i),
	.rd_data_o(rd_data_o), .reset_line_oe_n_o(reset_line_oe_n_o), .power_line_o(power_line_o),
	.power_line_oe_n_o(power_line_oe_n_o), .display_blank_o(display_blank_o),
	.backlight_off_o(backlight_off_o), .self_restart_o(self_restart_o)
);
`default_nettype wire

//--- verif/host_power_switch_watchdog_tb_top.sv
// Self-checking bench for the host power switch and watchdog block.
`timescale 1ns/1ns
`default_nettype none
`include "host_power_cfg.svh"
module host_power_switch_watchdog_tb_top;
	import host_power_pkg::*;
	localparam int unsigned TICK = 4;
	localparam int SEC = 32 * TICK;
	localparam logic [7:0] R_ATX = `HPW_CMD_ATX | `HPW_REPLY_BIT;
	localparam logic [7:0] R_WD = `HPW_CMD_WDOG | `HPW_REPLY_BIT;
	logic       mclk_i = 1'b0;
	logic       sys_rst_i = 1'b1;
	logic [7:0] addr_i = 8'h00;
	logic [7:0] wr_data_i = 8'h00;
	logic       wr_en_i = 1'b0;
	logic       rd_en_i = 1'b0;
	logic       sense_gpio_i = 1'b0;
	logic       key_confirm_i = 1'b0;
	logic       key_cancel_i = 1'b0;
	logic [7:0] rd_data_o;
	logic       standby_supply_i, reset_line_i, power_line_i;
	logic       reset_line_o, reset_line_oe_n_o, power_line_o, power_line_oe_n_o;
	logic       display_blank_o, backlight_off_o, self_restart_o;
	msg_t       msg_o;
	int         fails = 0;
	int         checks_done = 0;
	int         seed = 32'h61ebce10;
	logic       restart_seen = 1'b0;
	logic       rst_seen = 1'b0;
	always #2 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		if (self_restart_o === 1'b1) restart_seen <= 1'b1;
		if (reset_line_oe_n_o === 1'b0) rst_seen <= 1'b1;
	end
	host_power_switch_watchdog #(.TICK_CYCLES(TICK)) dut (
		.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
		.wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
		.standby_supply_i(standby_supply_i), .sense_gpio_i(sense_gpio_i),
		.key_confirm_i(key_confirm_i), .key_cancel_i(key_cancel_i),
		.reset_line_i(reset_line_i), .reset_line_o(reset_line_o),
		.reset_line_oe_n_o(reset_line_oe_n_o), .power_line_i(power_line_i),
		.power_line_o(power_line_o), .power_line_oe_n_o(power_line_oe_n_o),
		.display_blank_o(display_blank_o), .backlight_off_o(backlight_off_o),
		.self_restart_o(self_restart_o), .msg_o(msg_o));
	host_atx_model u_host (
		.clk_i(mclk_i), .rst_i(sys_rst_i), .pwr_oe_n_i(power_line_oe_n_o),
		.pwr_drv_i(power_line_o), .rst_oe_n_i(reset_line_oe_n_o), .rst_drv_i(reset_line_o),
		.pwr_line_o(power_line_i), .rst_line_o(reset_line_i), .host_on_o(standby_supply_i));
	task automatic summarize;
		$display("checks %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : summarize
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rng(input int n, input int lo, input int hi);
		chk(8'((n >= lo) && (n <= hi)), 8'h01);
	endtask : rng
	task automatic settle(input int c);
		repeat (c) @(posedge mclk_i);
		#1;
	endtask : settle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		wr_en_i <= 1'b1;
		addr_i <= a;
		wr_data_i <= d;
		@(posedge mclk_i);
		wr_en_i <= 1'b0;
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk_i);
		rd_en_i <= 1'b1;
		addr_i <= a;
		@(posedge mclk_i);
		rd_en_i <= 1'b0;
		#1;
		chk(rd_data_o, exp);
	endtask : rdc
	task automatic cmd(input logic [7:0] t, l, d0, d1, d2, rep);
		wr(`HPW_A_DATA0, d0);
		wr(`HPW_A_DATA1, d1);
		wr(`HPW_A_DATA2, d2);
		wr(`HPW_A_LEN, l);
		wr(`HPW_A_TYPE, t);
		@(posedge mclk_i);
		rdc(`HPW_A_REPLY, rep);
	endtask : cmd
	function automatic logic oe(input bit pw);
		return pw ? power_line_oe_n_o : reset_line_oe_n_o;
	endfunction : oe
	// Waits for a pulse on one line, then measures it and samples level and message.
	task automatic pulse(input bit pw, output int w, n, output logic lvl, output msg_t m);
		w = 0;
		n = 0;
		lvl = 1'bx;
		while (oe(pw) !== 1'b0 && w < 3000) begin
			settle(1);
			w++;
		end
		while (oe(pw) === 1'b0 && n < 3000) begin
			if (n == 2) begin
				lvl = pw ? power_line_o : reset_line_o;
				m = msg_o;
			end
			settle(1);
			n++;
		end
		if (w >= 3000 || n >= 3000) fails++;
	endtask : pulse
	initial begin
		#240000;
		fails++;
		summarize();
	end
	initial begin
		int w, n, len;
		logic lvl;
		msg_t m;
		logic [7:0] mk;
		repeat (4) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		rdc(`HPW_A_STAT + `HPW_SB_MASK, 8'h00);
		rdc(`HPW_A_STAT + `HPW_SB_SENSE, 8'h01);
		rdc(`HPW_A_STAT + `HPW_SB_WDOG, 8'h00);
		rdc(8'h20, 8'h00);
		cmd(`HPW_CMD_ATX, 8'h04, 8'h10, 8'h00, 8'h00, 8'h00);
		cmd(`HPW_CMD_WDOG, 8'h02, 8'h05, 8'h00, 8'h00, 8'h00);
		for (int i = 0; i < 3; i++) begin
			mk = 8'($random(seed)) & 8'h1f;
			cmd(`HPW_CMD_ATX, 8'h01, mk, 8'h00, 8'h00, R_ATX);
			rdc(`HPW_A_STAT + `HPW_SB_MASK, mk);
		end
		len = 2 + int'($unsigned($random(seed)) % 8);
		cmd(`HPW_CMD_ATX, 8'h03, 8'h54, 8'(len), 8'h01, R_ATX);
		settle(4);
		chk(8'(display_blank_o), 8'h01);
		restart_seen = 1'b0;
		@(posedge mclk_i);
		key_confirm_i <= 1'b1;
		pulse(1'b1, w, n, lvl, m);
		@(posedge mclk_i);
		key_confirm_i <= 1'b0;
		rng(w, 7 * TICK, 10 * TICK + 8);
		rng(n, (len - 1) * TICK, (len + 1) * TICK + 2);
		chk(8'(lvl), 8'h01);
		chk(8'(m), 8'(MSG_ON));
		settle(8);
		chk(8'(restart_seen), 8'h01);
		chk(8'(display_blank_o), 8'h00);
		cmd(`HPW_CMD_ATX, 8'h03, 8'h91, 8'h08, 8'h00, R_ATX);
		settle(6);
		chk(8'(display_blank_o), 8'h01);
		sense_gpio_i <= 1'b1;
		settle(6);
		chk(8'(display_blank_o), 8'h00);
		cmd(`HPW_CMD_ATX, 8'h03, 8'h91, 8'h08, 8'h01, R_ATX);
		@(posedge mclk_i);
		key_cancel_i <= 1'b1;
		pulse(1'b1, w, n, lvl, m);
		@(posedge mclk_i);
		key_cancel_i <= 1'b0;
		rng(w, 127 * TICK, 130 * TICK + 8);
		rng(n, 167 * TICK, 169 * TICK + 2);
		chk(8'(lvl), 8'h00);
		chk(8'(m), 8'(MSG_OFF));
		cmd(`HPW_CMD_ATX, 8'h03, 8'he1, 8'h04, 8'h01, R_ATX);
		@(posedge mclk_i);
		key_confirm_i <= 1'b1;
		pulse(1'b1, w, n, lvl, m);
		@(posedge mclk_i);
		key_confirm_i <= 1'b0;
		rng(n, 3 * TICK, 5 * TICK + 2);
		chk(8'(lvl), 8'h00);
		settle(8);
		restart_seen = 1'b0;
		@(posedge mclk_i);
		key_confirm_i <= 1'b1;
		pulse(1'b0, w, n, lvl, m);
		@(posedge mclk_i);
		key_confirm_i <= 1'b0;
		rng(w, 127 * TICK, 130 * TICK + 8);
		rng(n, 31 * TICK, 33 * TICK + 2);
		chk(8'(m), 8'(MSG_RESET));
		chk(8'(lvl), 8'h00);
		settle(4);
		chk(8'(restart_seen), 8'h01);
		cmd(`HPW_CMD_WDOG, 8'h01, 8'h03, 8'h00, 8'h00, R_WD);
		cmd(`HPW_CMD_WDOG, 8'h01, 8'h00, 8'h00, 8'h00, R_WD);
		rst_seen = 1'b0;
		settle(4 * SEC);
		chk(8'(rst_seen), 8'h00);
		// Three seconds of margin so the one-second wait below can never expire it.
		cmd(`HPW_CMD_WDOG, 8'h01, 8'h03, 8'h00, 8'h00, R_WD);
		rdc(`HPW_A_STAT + `HPW_SB_WDOG, 8'h03);
		settle(SEC);
		cmd(`HPW_CMD_WDOG, 8'h01, 8'h02, 8'h00, 8'h00, R_WD);
		pulse(1'b0, w, n, lvl, m);
		rng(w, SEC - 8, 2 * SEC + 16);
		rng(n, 31 * TICK, 33 * TICK + 2);
		chk(8'(m), 8'(MSG_NONE));
		rdc(`HPW_A_STAT + `HPW_SB_WDOG, 8'h00);
		rst_seen = 1'b0;
		settle(4 * SEC);
		chk(8'(rst_seen), 8'h00);
		// Length 255 holds the power line until the sensed host state moves.
		cmd(`HPW_CMD_ATX, 8'h03, 8'h81, 8'hff, 8'h00, R_ATX);
		@(posedge mclk_i);
		sense_gpio_i <= 1'b1;
		key_cancel_i <= 1'b1;
		while (power_line_oe_n_o !== 1'b0) settle(1);
		settle(40 * TICK);
		chk(8'(power_line_oe_n_o), 8'h00);
		@(posedge mclk_i);
		sense_gpio_i <= 1'b0;
		key_cancel_i <= 1'b0;
		settle(8);
		chk(8'(power_line_oe_n_o), 8'h01);
		summarize();
	end
endmodule : host_power_switch_watchdog_tb_top
`default_nettype wire
